// >>> bench/oag_asserts.sv
// checker for the operand address generator top level
// assumes it is bound onto oag_top and sees only its ports
`timescale 1ns/1ps
module oag_asserts (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // request side
    input wire logic         req_valid,
    input oag_pkg::oag_req_t req,
    input wire logic         req_ready,
    // result side
    input wire logic         res_valid,
    input oag_pkg::oag_res_t res,
    // memory side
    input wire logic         mem_ready,
    input wire logic         mem_req,
    input wire logic [19:0]  mem_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // request held from its take edge
    oag_pkg::oag_req_t rq_q;
    // second word of a wide operand is next
    logic              hi_q;
    // expected length, width and error of the held request
    logic [2:0]        len_e;
    logic              wide_e;
    logic              err_e;
    wire take = req_valid && req_ready;
    wire none = req.src_mode == oag_pkg::OAG_MODE_OTHER && req.dst_mode == oag_pkg::OAG_MODE_OTHER;
    wire rsvd = req.extended && !req.ext_word[6] && !req.bw;
    assign len_e = 3'h1 + {2'h0, rq_q.extended} + {2'h0, rq_q.src_mode != oag_pkg::OAG_MODE_OTHER}
                 + {2'h0, rq_q.dst_mode != oag_pkg::OAG_MODE_OTHER};
    assign wide_e = rq_q.extended && !rq_q.ext_word[6] && rq_q.bw;
    assign err_e = rq_q.extended && !rq_q.ext_word[6] && !rq_q.bw;
    // capture the request at the take
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) rq_q <= '0;
        else if (take) rq_q <= req;
    // toggle on every accepted word of a wide operand
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) hi_q <= 1'h0;
        else if (mem_req && mem_ready && res.wide) hi_q <= !hi_q;
    // quiet answer two cycles after the take
    sequence s_quiet;
        !mem_req ##1 (!mem_req && res_valid);
    endsequence
    // next word follows at the following even address
    sequence s_next_word;
        mem_req && mem_addr == $past(mem_addr) + oag_pkg::WORD_STEP;
    endsequence
    chk_ready_at_result: assert property (res_valid |-> req_ready)
        else $error("ready low with result");
    chk_take_busy: assert property (take |=> !req_ready)
        else $error("ready high after take");
    chk_result_pulse: assert property (res_valid |=> !res_valid)
        else $error("result valid longer than one cycle");
    chk_result_holds: assert property (!take |=> $stable(res))
        else $error("result changed without take");
    chk_word_held: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
        else $error("word request dropped or moved");
    chk_wide_step: assert property (mem_req && mem_ready && res.wide && !hi_q |=> s_next_word)
        else $error("second word not at next address");
    chk_no_access: assert property (take && (rsvd || none) |=> s_quiet)
        else $error("quiet request touched memory or answered late");
    chk_abs_addr: assert property (take && req.src_mode == oag_pkg::OAG_MODE_ABSOLUTE |=> res.src_addr ==
        (rq_q.extended ? {rq_q.ext_word[10:7], rq_q.src_index} : {4'h0, rq_q.src_index}))
        else $error("absolute source address wrong");
    chk_ext_index: assert property (take && req.extended && req.dst_mode == oag_pkg::OAG_MODE_INDEXED
        |=> res.dst_addr == rq_q.dst_base + {rq_q.ext_word[3:0], rq_q.dst_index})
        else $error("extended indexed destination wrong");
    chk_len_flags: assert property (res_valid |-> res.length == len_e && res.wide == wide_e
        && res.format_err == err_e)
        else $error("length or flags wrong");
endmodule // oag_asserts

bind oag_top oag_asserts u_chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .res_valid(res_valid), .res(res), .mem_ready(mem_ready),
    .mem_req(mem_req), .mem_addr(mem_addr));

// >>> bench/oag_mem_model.sv
// memory partner: accepts one word per ready, promptly or after stalls
// assumes word requests change only just after rising edges
`timescale 1ns/1ps
module oag_mem_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // stall control from the bench
    input  wire logic slow,
    // word access
    input  wire logic mem_req,
    output logic      mem_ready
);
    // stall count of the current word
    logic [1:0] wait_q;
    // count stalls between rising edges, restart per word
    always_ff @(negedge clk or negedge rst_n)
        if (!rst_n) wait_q <= 2'h0;
        else if (!mem_req || mem_ready) wait_q <= 2'h0;
        else wait_q <= wait_q + 2'h1;
    // one word at a time; when slow, one stall for a first word, two for a word that follows an accepted one
    assign mem_ready = mem_req && (!slow || wait_q == 2'h2);
endmodule // oag_mem_model

// >>> bench/operand_address_generator_tb.sv
// bench for the operand address generator
// assumes the memory model and the bound checker are compiled with it
`timescale 1ns/1ps
module operand_address_generator_tb;
    // clock, reset, stall control
    logic              clk       = 1'h0;
    logic              rst_n     = 1'h0;
    logic              slow      = 1'h0;
    // design ports
    logic              req_valid = 1'h0;
    oag_pkg::oag_req_t req       = '0;
    logic              req_ready, res_valid, mem_ready, mem_req;
    oag_pkg::oag_res_t res;
    logic [19:0]       mem_addr;
    // counters and log of accepted words
    int                n_fail      = 0;
    int                checks_done = 0;
    int                cycles      = 0;
    logic [19:0]       log_q[$];
    // short mode names
    localparam oag_pkg::oag_mode_t OT = oag_pkg::OAG_MODE_OTHER;
    localparam oag_pkg::oag_mode_t IX = oag_pkg::OAG_MODE_INDEXED;
    localparam oag_pkg::oag_mode_t SY = oag_pkg::OAG_MODE_SYMBOLIC;
    localparam oag_pkg::oag_mode_t AB = oag_pkg::OAG_MODE_ABSOLUTE;

    always #5 clk = ~clk;

    oag_top dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .res_valid(res_valid), .res(res), .mem_ready(mem_ready), .mem_req(mem_req), .mem_addr(mem_addr));
    oag_mem_model u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req), .mem_ready(mem_ready));

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // log accepted words, cut a hang short
    always @(posedge clk)
    begin
        if (mem_req && mem_ready) log_q.push_back(mem_addr);
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            summarize();
        end
    end

    // address compare
    task automatic cmp_addr(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t address %h want %h", $time, got, exp);
        end
    endtask

    // length or count compare
    task automatic cmp_len(input logic [2:0] got, input logic [2:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t count %h want %h", $time, got, exp);
        end
    endtask

    // flag compare
    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
        end
    endtask

    // build one decoded instruction
    function automatic oag_pkg::oag_req_t mk(input oag_pkg::oag_mode_t sm, input oag_pkg::oag_mode_t dm,
        input logic e, input logic [15:0] ew, input logic bw, input logic [19:0] pc, input logic [19:0] sb,
        input logic [19:0] db, input logic [15:0] si, input logic [15:0] di);
        mk = '{sm, dm, e, ew, bw, pc, sb, db, si, di};
    endfunction

    // one instruction: offer, wait for result, judge addresses, flags and words
    task automatic run(input oag_pkg::oag_req_t r, input logic [19:0] es, input logic [19:0] ed,
        input logic [2:0] el, input logic [1:0] fl, input logic [19:0] m[4], input int nm);
        @(negedge clk);
        req = r;
        req_valid = 1'h1;
        log_q.delete();
        while (req_ready !== 1'h1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'h0;
        do @(negedge clk); while (res_valid !== 1'h1);
        if (r.src_mode != OT) cmp_addr(res.src_addr, es);
        if (r.dst_mode != OT) cmp_addr(res.dst_addr, ed);
        cmp_len(res.length, el);
        cmp_bit(res.wide, fl[1]);
        cmp_bit(res.format_err, fl[0]);
        cmp_len(3'(log_q.size()), 3'(nm));
        for (int i = 0; i < nm; i++) cmp_addr(log_q[i], m[i]);
    endtask

    // extended indexed, wide data, stalling memory
    task automatic t_ext_indexed();
        slow = 1'h1;
        run(mk(IX, IX, 1'h1, 16'h0083, 1'h1, 20'h2_1032, 20'h2_3456, 20'h4_5678, 16'h2346, 16'h2100),
            20'h3_579c, 20'h7_7778, 3'h4, 2'h2, '{20'h3_579c, 20'h3_579e, 20'h7_7778, 20'h7_777a}, 4);
    endtask

    // short indexed below 64 KB, upper bits cleared
    task automatic t_short_indexed();
        slow = 1'h0;
        run(mk(IX, IX, 1'h0, 16'h0000, 1'h1, 20'h1_1034, 20'h0_479c, 20'h0_1778, 16'h1000, 16'hf000),
            20'h0_579c, 20'h0_0778, 3'h3, 2'h0, '{20'h0_579c, 20'h0_0778, 20'h0_0000, 20'h0_0000}, 2);
    endtask

    // short symbolic below 64 KB, index word addresses
    task automatic t_sym_low();
        run(mk(SY, SY, 1'h0, 16'h0000, 1'h1, 20'h0_1034, 20'h0_0000, 20'h0_0000, 16'h4766, 16'hf740),
            20'h0_579c, 20'h0_0778, 3'h3, 2'h0, '{20'h0_579c, 20'h0_0778, 20'h0_0000, 20'h0_0000}, 2);
    endtask

    // short symbolic above 64 KB with short absolute destination
    task automatic t_sym_high();
        run(mk(SY, AB, 1'h0, 16'h0000, 1'h0, 20'h2_f034, 20'h0_0000, 20'h0_0000, 16'h4766, 16'h8778),
            20'h3_379c, 20'h0_8778, 3'h3, 2'h0, '{20'h3_379c, 20'h0_8778, 20'h0_0000, 20'h0_0000}, 2);
    endtask

    // extended symbolic, byte data
    task automatic t_ext_sym();
        run(mk(SY, SY, 1'h1, 16'h00c5, 1'h1, 20'h2_1034, 20'h0_0000, 20'h0_0000, 16'h4766, 16'h6740),
            20'h3_579c, 20'h7_7778, 3'h4, 2'h0, '{20'h3_579c, 20'h7_7778, 20'h0_0000, 20'h0_0000}, 2);
    endtask

    // extended absolute at the top, wide wrap, negative extended index
    task automatic t_ext_abs_wrap();
        slow = 1'h1;
        run(mk(AB, IX, 1'h1, 16'h0788, 1'h1, 20'h0_0000, 20'h0_0000, 20'h4_0000, 16'hfffe, 16'h0000),
            20'hf_fffe, 20'hc_0000, 3'h4, 2'h2, '{20'hf_fffe, 20'h0_0000, 20'hc_0000, 20'hc_0002}, 4);
    endtask

    // short indexed above 64 KB wrapping into low memory
    task automatic t_short_wrap();
        slow = 1'h0;
        run(mk(IX, OT, 1'h0, 16'h0000, 1'h0, 20'h0_0000, 20'hf_f000, 20'h0_0000, 16'h2000, 16'h0000),
            20'h0_1000, 20'h0_0000, 3'h2, 2'h0, '{20'h0_1000, 20'h0_0000, 20'h0_0000, 20'h0_0000}, 1);
    endtask

    // reserved length code is refused without memory access
    task automatic t_reserved();
        run(mk(IX, OT, 1'h1, 16'h0000, 1'h0, 20'h0_0000, 20'h1_0000, 20'h0_0000, 16'h0010, 16'h0000),
            20'h1_0010, 20'h0_0000, 3'h3, 2'h1, '{20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_0000}, 0);
    endtask

    // reset, then every scenario back to back
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        t_ext_indexed();
        t_short_indexed();
        t_sym_low();
        t_sym_high();
        t_ext_sym();
        t_ext_abs_wrap();
        t_short_wrap();
        t_reserved();
        summarize();
    end
endmodule // operand_address_generator_tb

// >>> hw/oag_addr_calc.sv
// operand address generator: one effective address adder
// assumes inputs are stable, same clock domain, result used combinationally
`timescale 1ns/1ps
module oag_addr_calc (
    // decoded operand
    input  oag_pkg::oag_mode_t mode,
    input  wire logic          extended,
    // base values and index parts
    input  wire logic [19:0]   base_reg,
    input  wire logic [19:0]   index_pc,
    input  wire logic [15:0]   index_lo,
    input  wire logic [3:0]    index_hi,
    // effective address
    output logic [19:0]        addr
);

    logic [19:0] base_sel; // value the index is added to
    logic [19:0] idx_full; // index widened to 20 bits
    logic [19:0] sum;      // wrapped sum

    // select base and widen index, then add
    always_comb
    begin
        base_sel = oag_pkg::ADDR_RST;
        idx_full = {index_hi, index_lo}; // RULE3
        unique case (mode)
            oag_pkg::OAG_MODE_INDEXED:  base_sel = base_reg;   // RULE1
            oag_pkg::OAG_MODE_SYMBOLIC: base_sel = index_pc;   // RULE13 RULE12
            default:                    base_sel = oag_pkg::ADDR_RST; // RULE16
        endcase
        if (!extended)
        begin
            // short form: signed index, absolute index is unsigned
            if (mode == oag_pkg::OAG_MODE_ABSOLUTE)
                idx_full = {oag_pkg::LOW_PAGE, index_lo}; // RULE15
            else
                idx_full = {{4{index_lo[15]}}, index_lo}; // RULE11
        end
        // carry out of bit 19 is dropped
        sum = base_sel + idx_full; // RULE18 RULE2
        addr = sum;
        // short form with base in lower 64 KB stays there
        if (!extended && mode != oag_pkg::OAG_MODE_ABSOLUTE && base_sel[19:16] == oag_pkg::LOW_PAGE)
            addr = sum & oag_pkg::LOW64K_MASK; // RULE9
    end

endmodule // oag_addr_calc

// >>> hw/oag_top.sv
// operand address generator: top level
// assumes the decoder and memory run on clk; base registers are read only
//
// Contract
// RULE1: extended indexed: base plus 20-bit index
// RULE2: extended indexed reaches base plus or minus 19 bits
// RULE3: index high nibble from prefix, low from word
// RULE4: one prefix word serves both operands
// RULE5: 20-bit data needs length bits 01
// RULE6: base register is never modified
// RULE7: extended forms are three or four words
// RULE8: all three modes for source and destination
// RULE9: short form in lower 64 KB clears 19:16
// RULE10: program counter is never modified
// RULE11: upper short symbolic: signed index, full PC
// RULE12: PC used is the index word address
// RULE13: extended symbolic: full PC plus 20-bit index
// RULE14: short forms are two or three words
// RULE15: short absolute: word used as address directly
// RULE16: extended absolute: 20-bit address from zero
// RULE17: 20-bit data is two consecutive words
// RULE18: carries beyond bit 19 are dropped
`timescale 1ns/1ps
module oag_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // decoded instruction in
    input  wire logic        req_valid,
    input  oag_pkg::oag_req_t req,
    output logic             req_ready,
    // computed addresses out
    output logic             res_valid,
    output oag_pkg::oag_res_t res,
    // memory word access
    input  wire logic        mem_ready,
    output logic             mem_req,
    output logic [19:0]      mem_addr
);

    // decoded request fields
    logic        src_used;     // source takes an index word
    logic        dst_used;     // destination takes an index word
    logic [1:0]  al_bw;        // address-length and byte-word bits
    logic        wide;         // 20-bit data operands
    logic        fmt_err;      // reserved length code
    logic [3:0]  src_hi;       // source index upper bits
    logic [3:0]  dst_hi;       // destination index upper bits
    logic [19:0] src_pc;       // address of source index word
    logic [19:0] dst_pc;       // address of destination index word
    logic [19:0] src_addr;     // source effective address
    logic [19:0] dst_addr;     // destination effective address
    logic [2:0]  length;       // instruction length in words

    // sequencing registers
    oag_pkg::oag_state_t state_q;    // current state
    oag_pkg::oag_res_t   res_q;      // held result
    logic                res_valid_q;// result pulse
    logic                src_used_q; // source access pending
    logic                dst_used_q; // destination access pending
    logic                seq_start_q;// start one operand access
    logic [19:0]         seq_addr_q; // address for that access
    logic                ready_q;    // registered ready level
    logic                seq_done;   // operand access finished

    // decode the shared prefix word
    always_comb
    begin
        src_used = req.src_mode != oag_pkg::OAG_MODE_OTHER; // RULE8
        dst_used = req.dst_mode != oag_pkg::OAG_MODE_OTHER; // RULE8
        // both upper nibbles and the length bit share one word
        src_hi = req.ext_word[oag_pkg::EXT_SRC_LSB +: oag_pkg::MSB_W]; // RULE4
        dst_hi = req.ext_word[oag_pkg::EXT_DST_LSB +: oag_pkg::MSB_W]; // RULE4
        al_bw  = {req.ext_word[oag_pkg::EXT_AL_BIT], req.bw};
        // 20-bit data only in byte form
        wide    = req.extended && (al_bw == oag_pkg::AL_BW_20BIT); // RULE5
        fmt_err = req.extended && (al_bw == oag_pkg::AL_BW_RSVD);  // RULE5
    end

    // addresses of the index words behind the instruction
    always_comb
    begin
        // source index follows the instruction word
        src_pc = req.instr_pc + oag_pkg::WORD_STEP; // RULE12 RULE18
        // destination index follows the source index, if any
        dst_pc = src_pc;
        if (src_used)
        begin
            dst_pc = src_pc + oag_pkg::WORD_STEP; // RULE12
        end
    end

    // count the words of the instruction
    always_comb
    begin
        length = oag_pkg::LEN_INSTR;
        if (req.extended)
        begin
            // prefix word
            length = length + oag_pkg::LEN_ONE; // RULE7
        end
        if (src_used)
        begin
            length = length + oag_pkg::LEN_ONE; // RULE14
        end
        if (dst_used)
        begin
            length = length + oag_pkg::LEN_ONE; // RULE14
        end
    end

    // source operand address
    oag_addr_calc u_src_calc (
        .mode     (req.src_mode),
        .extended (req.extended),
        .base_reg (req.src_base),
        .index_pc (src_pc),
        .index_lo (req.src_index),
        .index_hi (src_hi),
        .addr     (src_addr)
    );

    // destination operand address
    oag_addr_calc u_dst_calc (
        .mode     (req.dst_mode),
        .extended (req.extended),
        .base_reg (req.dst_base),
        .index_pc (dst_pc),
        .index_lo (req.dst_index),
        .index_hi (dst_hi),
        .addr     (dst_addr)
    );

    // operand word accesses on the memory bus
    oag_word_seq u_seq (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (seq_start_q),
        .start_addr (seq_addr_q),
        .wide       (res_q.wide),
        .mem_ready  (mem_ready),
        .mem_req    (mem_req),
        .mem_addr   (mem_addr),
        .done       (seq_done)
    );

    // state sequencing: take, access source, access destination, answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= oag_pkg::OAG_IDLE;
        end
        else
        begin
            unique case (state_q)
                oag_pkg::OAG_IDLE:
                begin
                    // faulty length code skips the accesses
                    if (req_valid && fmt_err)
                    begin
                        state_q <= oag_pkg::OAG_DONE;
                    end
                    else if (req_valid && src_used)
                    begin
                        // source first
                        state_q <= oag_pkg::OAG_SRC;
                    end
                    else if (req_valid && dst_used)
                    begin
                        // destination only
                        state_q <= oag_pkg::OAG_DST;
                    end
                    else if (req_valid)
                    begin
                        // nothing to access
                        state_q <= oag_pkg::OAG_DONE;
                    end
                end
                oag_pkg::OAG_SRC:
                begin
                    // destination follows once source is read
                    if (seq_done && dst_used_q)
                    begin
                        state_q <= oag_pkg::OAG_DST;
                    end
                    else if (seq_done)
                    begin
                        state_q <= oag_pkg::OAG_DONE;
                    end
                end
                oag_pkg::OAG_DST:
                begin
                    if (seq_done)
                    begin
                        state_q <= oag_pkg::OAG_DONE;
                    end
                end
                oag_pkg::OAG_DONE:
                begin
                    state_q <= oag_pkg::OAG_IDLE;
                end
                default:
                begin
                    // illegal code recovers to idle
                    state_q <= oag_pkg::OAG_IDLE;
                end
            endcase
        end
    end

    // capture the computed result when a request is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_q      <= '0;
            src_used_q <= 1'b0;
            dst_used_q <= 1'b0;
        end
        else if (state_q == oag_pkg::OAG_IDLE && req_valid)
        begin
            // base and PC are only read, never written back
            res_q.src_addr   <= src_addr;   // RULE6 RULE10
            res_q.dst_addr   <= dst_addr;   // RULE6 RULE10
            res_q.length     <= length;     // RULE7 RULE14
            res_q.wide       <= wide;       // RULE17
            res_q.format_err <= fmt_err;    // RULE5
            src_used_q       <= src_used;
            dst_used_q       <= dst_used;
        end
    end

    // launch each operand access
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_start_q <= 1'b0;
            seq_addr_q  <= oag_pkg::ADDR_RST;
        end
        else
        begin
            seq_start_q <= 1'b0;
            if (state_q == oag_pkg::OAG_IDLE && req_valid && !fmt_err && src_used)
            begin
                // source first
                seq_start_q <= 1'b1;
                seq_addr_q  <= src_addr;
            end
            else if (state_q == oag_pkg::OAG_IDLE && req_valid && !fmt_err && dst_used)
            begin
                // destination only
                seq_start_q <= 1'b1;
                seq_addr_q  <= dst_addr;
            end
            else if (state_q == oag_pkg::OAG_SRC && seq_done && dst_used_q)
            begin
                // destination after source
                seq_start_q <= 1'b1;
                seq_addr_q  <= res_q.dst_addr;
            end
        end
    end

    // ready level, high exactly while idle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_q <= 1'b1;
        end
        else if (state_q == oag_pkg::OAG_IDLE)
        begin
            // an offer is taken at once
            ready_q <= !req_valid;
        end
        else
        begin
            // idle follows the answer or a bad code
            ready_q <= state_q != oag_pkg::OAG_SRC && state_q != oag_pkg::OAG_DST;
        end
    end

    // answer pulse, one cycle after the done state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_valid_q <= 1'b0;
        end
        else
        begin
            res_valid_q <= state_q == oag_pkg::OAG_DONE;
        end
    end

    // outputs straight from flip-flops
    assign req_ready = ready_q;
    assign res_valid = res_valid_q;
    assign res       = res_q;

endmodule // oag_top

// >>> hw/oag_word_seq.sv
// operand address generator: memory word access sequencer
// assumes mem_ready comes from memory logic on the same clock
`timescale 1ns/1ps
module oag_word_seq (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // start of one operand access
    input  wire logic        start,
    input  wire logic [19:0] start_addr,
    input  wire logic        wide,
    // memory side
    input  wire logic        mem_ready,
    output logic             mem_req,
    output logic [19:0]      mem_addr,
    // end of the operand access
    output logic             done
);

    logic        req_q;     // access outstanding
    logic [19:0] addr_q;    // current word address
    logic        second_q;  // one more word follows
    logic        done_q;    // one-cycle completion

    // walk one or two consecutive words
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_q    <= 1'b0;
            addr_q   <= oag_pkg::ADDR_RST;
            second_q <= 1'b0;
            done_q   <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                req_q    <= 1'b1;
                addr_q   <= start_addr;
                second_q <= wide; // RULE17
            end
            else if (req_q && mem_ready)
            begin
                if (second_q)
                begin
                    // next word of a 20-bit operand
                    addr_q   <= addr_q + oag_pkg::WORD_STEP; // RULE17
                    second_q <= 1'b0;
                end
                else
                begin
                    req_q  <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign mem_req  = req_q;
    assign mem_addr = addr_q;
    assign done     = done_q;

endmodule // oag_word_seq

// >>> shared/oag_pkg.sv
// operand address generator: shared constants and types
// assumes one 100 MHz clock, async active-low reset, byte addressed memory
package oag_pkg;

    // widths of the address space and of the code words
    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;
    localparam int MSB_W  = 4;

    // extension word fields: upper index bits and address-length bit
    localparam int EXT_SRC_LSB = 7;
    localparam int EXT_DST_LSB = 0;
    localparam int EXT_AL_BIT  = 6;

    // address-length:byte-word code that selects 20-bit data
    localparam logic [1:0] AL_BW_20BIT = 2'h1;
    // address-length:byte-word code that is reserved
    localparam logic [1:0] AL_BW_RSVD  = 2'h0;

    // keeps an address within the lower 64 KB
    localparam logic [19:0] LOW64K_MASK = 20'h0_ffff;
    // distance between two consecutive memory words
    localparam logic [19:0] WORD_STEP   = 20'h0_0002;
    // value of every address register after reset
    localparam logic [19:0] ADDR_RST    = 20'h0_0000;
    // upper nibble of an address in the lower 64 KB
    localparam logic [3:0]  LOW_PAGE    = 4'h0;
    // instruction word alone; one prefix or index word; no word
    localparam logic [2:0]  LEN_INSTR   = 3'h1;
    localparam logic [2:0]  LEN_ONE     = 3'h1;
    localparam logic [2:0]  LEN_NONE    = 3'h0;

    // operand addressing mode as decoded by the caller
    typedef enum logic [1:0] {
        OAG_MODE_OTHER    = 2'h0,
        OAG_MODE_INDEXED  = 2'h1,
        OAG_MODE_SYMBOLIC = 2'h2,
        OAG_MODE_ABSOLUTE = 2'h3
    } oag_mode_t;

    // one decoded instruction as handed over by the decoder
    typedef struct packed {
        oag_mode_t   src_mode;
        oag_mode_t   dst_mode;
        logic        extended;
        logic [15:0] ext_word;
        logic        bw;
        logic [19:0] instr_pc;
        logic [19:0] src_base;
        logic [19:0] dst_base;
        logic [15:0] src_index;
        logic [15:0] dst_index;
    } oag_req_t;

    // computed addresses and instruction length
    typedef struct packed {
        logic [19:0] src_addr;
        logic [19:0] dst_addr;
        logic [2:0]  length;
        logic        wide;
        logic        format_err;
    } oag_res_t;

    // sequencing states, one-hot
    typedef enum logic [3:0] {
        OAG_IDLE = 4'h1,
        OAG_SRC  = 4'h2,
        OAG_DST  = 4'h4,
        OAG_DONE = 4'h8
    } oag_state_t;

endpackage
